//--- common/dcb_defs.svh
// Purpose: Shared constants of the dual counter with byte readout
// Assumes: Included by bare name, definitions only
// Notes:   Times are in ns, counts in cycles of I_CLK
`ifndef DCB_DEFS_SVH
`define DCB_DEFS_SVH

// Widths
`define DCB_CNT_W        16
`define DCB_BYTE_W       8
`define DCB_SNAP_W       32
`define DCB_SEL_W        4
`define DCB_SYNC_W       8

// Reset values, full count and count step
`define DCB_CNT_RST      16'h0000
`define DCB_CNT_FULL     16'hffff
`define DCB_CNT_ONE      16'h0001
`define DCB_SNAP_RST     32'h0000_0000
`define DCB_BYTE_RST     8'h00

// Field positions inside the snapshot
`define DCB_ONE_LO_LSB   0
`define DCB_ONE_HI_LSB   8
`define DCB_TWO_LO_LSB   16
`define DCB_TWO_HI_LSB   24

// Bit positions inside the synchroniser vector
`define DCB_SY_CLK1      0
`define DCB_SY_CLK2      1
`define DCB_SY_SNAP      2
`define DCB_SY_EN2       3
`define DCB_SY_SEL       4

// Timing
`define DCB_CLK_NS       40
`define DCB_CLR_MIN_NS   20
`define DCB_CLR_MIN_CYC  (((`DCB_CLR_MIN_NS + `DCB_CLK_NS - 1) / `DCB_CLK_NS) < 1 ? 1 : \
                          ((`DCB_CLR_MIN_NS + `DCB_CLK_NS - 1) / `DCB_CLK_NS))

`endif

//--- common/dcb_pkg.sv
// Purpose: Types of the dual counter with byte readout
// Assumes: Widths come from dcb_defs.svh
// Notes:   Byte choice is an enum so the output decode has one home
`include "dcb_defs.svh"
package dcb_pkg;
    typedef logic [`DCB_CNT_W-1:0]  dcb_cnt_t;   // One counter
    typedef logic [`DCB_SNAP_W-1:0] dcb_snap_t;  // Both counters
    typedef logic [`DCB_BYTE_W-1:0] dcb_byte_t;  // One readout byte
    typedef logic [`DCB_SEL_W-1:0]  dcb_sel_t;   // Active-low selects
    // Which snapshot byte is on the read bus
    typedef enum logic [2:0] {
        DCB_PICK_NONE,
        DCB_PICK_ONE_LO,
        DCB_PICK_ONE_HI,
        DCB_PICK_TWO_LO,
        DCB_PICK_TWO_HI
    } dcb_pick_t;
endpackage

//--- rtl/dcb_sync.sv
// Purpose: Two-flop synchronisers with rising-edge detect per bit
// Assumes: Inputs are pins, asynchronous to i_clk
// Notes:   Stage one feeds only stage two; edges come from stage two on
`timescale 1ns/10ps
module dcb_sync
    import dcb_pkg::*;
#(
    parameter int W = `DCB_SYNC_W
) (
    // Clock, reset, enable
    input  wire logic         i_clk,
    input  wire logic         i_arst_n,
    input  wire logic         i_ce,
    // Pins in
    input  wire logic [W-1:0] i_pin,
    // Synchronised level and rising pulse
    output logic      [W-1:0] o_level,
    output logic      [W-1:0] o_rise
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta;   // First stage, read only by second
            logic sync;   // Second stage, safe level
            logic prev;   // Delayed copy for edge detect

            // Shift chain, frozen with the clock enable
            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    meta <= 1'b0;
                    sync <= 1'b0;
                    prev <= 1'b0;
                end else if (i_ce) begin
                    meta <= i_pin[g];
                    sync <= meta;
                    prev <= sync;
                end
            end

            assign o_level[g] = sync;
            // Only low-to-high counts; falling edges are ignored
            assign o_rise[g]  = sync & ~prev;
        end
    endgenerate
endmodule

//--- rtl/dcb_top.sv
// Purpose: Two 16-bit up-counters, shared snapshot, byte-wide readout
// Assumes: Count, snapshot and select pins are slow next to I_CLK
// Notes:   Count, enable, snapshot and select pins are synchronised, so each pin level must last
//          at least three I_CLK periods to be seen
//
// Functional notes
// - Two 16-bit counters, each own clock
// - Only rising clock edges change state
// - Carry low while counter one full
// - Counter two counts only when enable low
// - Chained pair acts as 32-bit counter
// - Clear low zeroes both counters asynchronously
// - Snapshot edge copies both counters together
// - Snapshot holds until next snapshot edge
// - Each half split into low, high bytes
// - Active-low selects pick byte for bus
// - Selects map one-lo, one-hi, two-lo, two-hi
// - All selects high floats the bus
// - Counters wrap after 65535, chained 4294967295
`timescale 1ns/10ps
module dcb_top
    import dcb_pkg::*;
(
    // System clock, reset, clock enable
    input  wire logic             I_CLK,
    input  wire logic             I_ARST_N,
    input  wire logic             I_CE,
    // Count clocks and counter control pins
    input  wire logic             I_COUNT_CLOCK_ONE,
    input  wire logic             I_COUNT_CLOCK_TWO,
    input  wire logic             I_COUNT_TWO_ENABLE_N,
    input  wire logic             I_COUNTERS_CLEAR_N,
    // Snapshot clock pin
    input  wire logic             I_SNAP_CLOCK,
    // Byte selects, active low
    input  wire logic             I_SEL_ONE_LOW_BYTE_N,
    input  wire logic             I_SEL_ONE_HIGH_BYTE_N,
    input  wire logic             I_SEL_TWO_LOW_BYTE_N,
    input  wire logic             I_SEL_TWO_HIGH_BYTE_N,
    // Carry of counter one, active low
    output logic                  O_CARRY_OUT_ONE_N,
    // Read bus, output only, with its enable
    output logic [`DCB_BYTE_W-1:0] O_READ_BUS,
    output logic                  O_READ_BUS_OE
);
    // Synchroniser outputs
    logic [`DCB_SYNC_W-1:0] sy_level;   // Clean pin levels
    logic [`DCB_SYNC_W-1:0] sy_rise;    // One-cycle rising pulses
    logic                   rise_one;   // Count clock one edge
    logic                   rise_two;   // Count clock two edge
    logic                   rise_snap;  // Snapshot clock edge
    logic                   en_two_n;   // Synchronised enable
    dcb_sel_t               sel_n;      // Synchronised selects

    // Counter state
    dcb_cnt_t   cnt_one;        // Counter one
    dcb_cnt_t   cnt_two;        // Counter two
    dcb_cnt_t   next_cnt_one;   // Counter one after this cycle
    dcb_cnt_t   next_cnt_two;   // Counter two after this cycle
    logic       cnt_rst_n;      // Reset or clear, both active low

    // Snapshot and readout
    dcb_snap_t  snapshot;       // Captured counter pair
    dcb_pick_t  pick;           // Decoded byte choice
    dcb_byte_t  next_read;      // Byte to drive next

    // Pick one byte choice from the active-low selects
    function automatic dcb_pick_t pick_of(input dcb_sel_t s_n);
        dcb_pick_t p;
        p = DCB_PICK_NONE;
        // Several selects low is illegal; lowest index wins so it stays defined
        if (!s_n[0]) begin
            p = DCB_PICK_ONE_LO;
        end else if (!s_n[1]) begin
            p = DCB_PICK_ONE_HI;
        end else if (!s_n[2]) begin
            p = DCB_PICK_TWO_LO;
        end else if (!s_n[3]) begin
            p = DCB_PICK_TWO_HI;
        end
        return p;
    endfunction

    // Pull one byte out of the snapshot
    function automatic dcb_byte_t byte_of(input dcb_snap_t s, input dcb_pick_t p);
        dcb_byte_t b;
        b = `DCB_BYTE_RST;
        case (p)
            DCB_PICK_ONE_LO: begin
                b = s[`DCB_ONE_LO_LSB +: `DCB_BYTE_W];
            end
            DCB_PICK_ONE_HI: begin
                b = s[`DCB_ONE_HI_LSB +: `DCB_BYTE_W];
            end
            DCB_PICK_TWO_LO: begin
                b = s[`DCB_TWO_LO_LSB +: `DCB_BYTE_W];
            end
            DCB_PICK_TWO_HI: begin
                b = s[`DCB_TWO_HI_LSB +: `DCB_BYTE_W];
            end
            default: begin
                b = `DCB_BYTE_RST;
            end
        endcase
        return b;
    endfunction

    // Count, enable, snapshot and select pins go through the synchroniser bank; clear does not
    // Selects pass inverted so the chain's reset value is their idle
    // level; otherwise the bus would be driven for two cycles after reset
    dcb_sync #(
        .W        (`DCB_SYNC_W)
    ) u_sync (
        .i_clk    (I_CLK),
        .i_arst_n (I_ARST_N),
        .i_ce     (I_CE),
        .i_pin    ({~I_SEL_TWO_HIGH_BYTE_N, ~I_SEL_TWO_LOW_BYTE_N,
                    ~I_SEL_ONE_HIGH_BYTE_N, ~I_SEL_ONE_LOW_BYTE_N,
                    I_COUNT_TWO_ENABLE_N, I_SNAP_CLOCK,
                    I_COUNT_CLOCK_TWO, I_COUNT_CLOCK_ONE}),
        .o_level  (sy_level),
        .o_rise   (sy_rise)
    );

    // Rising pulses only for count and snapshot clocks; a falling clock pin edge never reaches the state
    assign rise_one  = sy_rise[`DCB_SY_CLK1];
    assign rise_two  = sy_rise[`DCB_SY_CLK2];
    assign rise_snap = sy_rise[`DCB_SY_SNAP];
    assign en_two_n  = sy_level[`DCB_SY_EN2];
    // Back to active low; all high right after reset, so the bus floats
    assign sel_n     = ~sy_level[`DCB_SY_SEL +: `DCB_SEL_W];
    assign pick      = pick_of(sel_n);

    // Clear acts without the clock; release is not synchronised, so
    // the driver must keep it clean and off count edges
    assign cnt_rst_n = I_ARST_N & I_COUNTERS_CLEAR_N;

    // Next value of counter one, wrapping past all ones
    always_comb begin
        next_cnt_one = cnt_one;
        if (rise_one) begin
            next_cnt_one = cnt_one + `DCB_CNT_ONE;
        end
    end

    // Next value of counter two, gated by its active-low enable
    always_comb begin
        next_cnt_two = cnt_two;
        // Chained: enable is the carry, so two moves once per wrap of one
        if (rise_two && !en_two_n) begin
            next_cnt_two = cnt_two + `DCB_CNT_ONE;
        end
    end

    // Counter one register
    always_ff @(posedge I_CLK or negedge cnt_rst_n) begin
        if (!cnt_rst_n) begin
            cnt_one <= `DCB_CNT_RST;
        end else if (I_CE) begin
            cnt_one <= next_cnt_one;
        end
    end

    // Counter two register
    always_ff @(posedge I_CLK or negedge cnt_rst_n) begin
        if (!cnt_rst_n) begin
            cnt_two <= `DCB_CNT_RST;
        end else if (I_CE) begin
            cnt_two <= next_cnt_two;
        end
    end

    // Carry follows the next count so it is aligned with the counter
    always_ff @(posedge I_CLK or negedge cnt_rst_n) begin
        if (!cnt_rst_n) begin
            O_CARRY_OUT_ONE_N <= 1'b1;
        end else if (I_CE) begin
            O_CARRY_OUT_ONE_N <= (next_cnt_one != `DCB_CNT_FULL);
        end
    end

    // Snapshot: not touched by clear, only by its own edge
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            snapshot <= `DCB_SNAP_RST;
        end else if (I_CE && rise_snap) begin
            snapshot <= {cnt_two, cnt_one};
        end
    end

    // Byte to drive, decoded from the selects
    always_comb begin
        next_read = byte_of(snapshot, pick);
    end

    // Read bus data and enable, registered
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_READ_BUS    <= `DCB_BYTE_RST;
            O_READ_BUS_OE <= 1'b0;
        end else if (I_CE) begin
            O_READ_BUS    <= next_read;
            // Bus floats whenever no select is low
            O_READ_BUS_OE <= (pick != DCB_PICK_NONE);
        end
    end

    // ---- Checks ----
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!cnt_rst_n);

    sequence s_one_edge;
        I_CE && rise_one;
    endsequence

    sequence s_two_edge_on;
        I_CE && rise_two && !en_two_n;
    endsequence

    sequence s_snap_edge;
        I_CE && rise_snap;
    endsequence

    a_one_counts_up: assert property (s_one_edge |=> cnt_one == $past(cnt_one) + `DCB_CNT_ONE)
        else $error("counter one did not step by one");
    a_one_holds: assert property (!(I_CE && rise_one) |=> $stable(cnt_one))
        else $error("counter one moved without a rising edge");
    a_one_wraps: assert property (s_one_edge ##0 (cnt_one == `DCB_CNT_FULL) |=> cnt_one == `DCB_CNT_RST)
        else $error("counter one did not wrap to zero");
    a_carry_full: assert property (O_CARRY_OUT_ONE_N == (cnt_one != `DCB_CNT_FULL))
        else $error("carry does not match full count");
    a_two_counts_up: assert property (s_two_edge_on |=> cnt_two == $past(cnt_two) + `DCB_CNT_ONE)
        else $error("counter two did not step while enabled");
    a_two_gated: assert property (I_CE && rise_two && en_two_n |=> $stable(cnt_two))
        else $error("counter two moved while disabled");
    a_clear_zero: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        !I_COUNTERS_CLEAR_N |-> (cnt_one == `DCB_CNT_RST) && (cnt_two == `DCB_CNT_RST))
        else $error("clear did not zero the counters");
    a_snap_capture: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        s_snap_edge |=> snapshot == {$past(cnt_two), $past(cnt_one)})
        else $error("snapshot did not capture both counters");
    a_snap_holds: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        !(I_CE && rise_snap) |=> $stable(snapshot))
        else $error("snapshot changed without its edge");
    a_float_idle: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        I_CE && (sel_n == 4'hf) |=> !O_READ_BUS_OE)
        else $error("bus driven with no select low");
    a_byte_one_hi: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        I_CE && (sel_n == 4'hd) |=> O_READ_BUS_OE && O_READ_BUS == $past(snapshot[15:8]))
        else $error("wrong byte for counter one high");
    a_byte_two_lo: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
        I_CE && (sel_n == 4'hb) |=> O_READ_BUS_OE && O_READ_BUS == $past(snapshot[23:16]))
        else $error("wrong byte for counter two low");
endmodule

//--- bench/dcb_host.sv
// Purpose: Host model, decoder offsets to byte reads, snapshot and clear
// Assumes: Drives its strobes just after the falling edge of i_clk
// Notes:   A released read bus reads back as the inverse of the last byte
`timescale 1ns/10ps
module dcb_host
    import dcb_pkg::*;
(
    // Clock
    input  wire logic      i_clk,
    // Read bus as resolved on the wire
    input  wire dcb_byte_t i_read_bus,
    // Decoded strobes toward the device
    output dcb_sel_t       o_sel_n,
    output logic           o_snap_clock,
    output logic           o_clear_n
);
    dcb_byte_t last;  // Last byte taken, for the released-bus pattern

    // Idle levels at time zero
    initial begin
        o_sel_n      = 4'hf;
        o_snap_clock = 1'b0;
        o_clear_n    = 1'b1;
        last         = 8'h00;
    end

    // One decoder access; offsets 6 and 7 do nothing
    task automatic access(input logic [2:0] off, output dcb_byte_t data);
        data = 8'h00;
        @(negedge i_clk);
        case (off)
            3'h0, 3'h1, 3'h2, 3'h3: begin
                o_sel_n[off[1:0]] = 1'b0;
                repeat (5) @(negedge i_clk);
                // A floating bus must not pass for the last value
                data = (^i_read_bus === 1'bx) ? ~last : i_read_bus;
                last = data;
                o_sel_n = 4'hf;
                // All selects high for a full Z period before the next
                repeat (5) @(negedge i_clk);
            end
            3'h4: begin
                o_snap_clock = 1'b1;
                repeat (4) @(negedge i_clk);
                o_snap_clock = 1'b0;
                repeat (4) @(negedge i_clk);
            end
            3'h5: begin
                o_clear_n = 1'b0;
                repeat (2) @(negedge i_clk);
                o_clear_n = 1'b1;
                repeat (4) @(negedge i_clk);
            end
            default: begin
                @(negedge i_clk);
            end
        endcase
    endtask
endmodule

//--- bench/dcb_top_test.sv
// Purpose: Self-checking bench of the dual counter with byte readout
// Assumes: Pins change at the falling edge and hold three I_CLK periods or more, clear only two
// Notes:   Full count is never reached: 65535 slow pulses would overrun
//          the run length, so carry is only seen in its high state
`timescale 1ns/10ps
module dcb_top_test;
    import dcb_pkg::*;
    logic      I_CLK, I_ARST_N, I_CE;          // Clock, reset, enable
    logic      pin_one, pin_two, en_two_n;     // Count pins as driven
    logic      chain;                          // Chained wiring on
    wire       carry_n, oe, snap, clr_n;       // Device and host strobes
    dcb_byte_t bus_raw;                        // Bus before three-state
    wire [7:0] read_bus;                       // Resolved bus
    dcb_sel_t  sel_n;                          // Host byte selects
    int        errors, checked, cycles;        // Counters
    logic [31:0] seed, prev;                   // Random state, old snapshot
    dcb_cnt_t  exp_one, exp_two;               // Expected counts

    assign read_bus = oe ? bus_raw : 8'hzz;

    dcb_top u_dut (
        .I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_CE(I_CE),
        .I_COUNT_CLOCK_ONE(pin_one),
        .I_COUNT_CLOCK_TWO(chain ? pin_one : pin_two),
        .I_COUNT_TWO_ENABLE_N(chain ? carry_n : en_two_n),
        .I_COUNTERS_CLEAR_N(clr_n), .I_SNAP_CLOCK(snap),
        .I_SEL_ONE_LOW_BYTE_N(sel_n[0]), .I_SEL_ONE_HIGH_BYTE_N(sel_n[1]),
        .I_SEL_TWO_LOW_BYTE_N(sel_n[2]), .I_SEL_TWO_HIGH_BYTE_N(sel_n[3]),
        .O_CARRY_OUT_ONE_N(carry_n), .O_READ_BUS(bus_raw), .O_READ_BUS_OE(oe)
    );
    dcb_host u_host (.i_clk(I_CLK), .i_read_bus(read_bus), .o_sel_n(sel_n),
                     .o_snap_clock(snap), .o_clear_n(clr_n));

    // Clock of 40 ns
    initial begin
        I_CLK = 1'b0;
        forever #20 I_CLK = ~I_CLK;
    end

    // Hang guard; the longest sequence needs well under this
    always @(posedge I_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
    end

    // Xorshift step, repeatable from its fixed start
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Snapshot image: counter two above counter one
    function automatic logic [31:0] exp_snap(input dcb_cnt_t one, input dcb_cnt_t two);
        return {two, one};
    endfunction

    // Compare one value
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One count pulse on the chosen pins, high four periods, low three
    task automatic pulse(input logic a, input logic b);
        @(negedge I_CLK);
        pin_one = a;
        pin_two = b;
        repeat (4) @(negedge I_CLK);
        pin_one = 1'b0;
        pin_two = 1'b0;
        repeat (3) @(negedge I_CLK);
    endtask

    // Four byte reads, no capture
    task automatic read_bytes(output logic [31:0] v);
        dcb_byte_t b;
        for (int k = 0; k < 4; k++) begin
            u_host.access(k[2:0], b);
            v[8*k +: 8] = b;
        end
    endtask

    // Capture then read back
    task automatic snap_read(output logic [31:0] v);
        dcb_byte_t b;
        u_host.access(3'h4, b);
        read_bytes(v);
    endtask

    // Verdict and stop
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Main sequence
    initial begin
        int n1, n2;
        dcb_byte_t b;
        logic [31:0] v;
        {I_ARST_N, pin_one, pin_two, en_two_n, chain} = 5'b0;
        I_CE = 1'b1;
        errors = 0; checked = 0; cycles = 0;
        seed = 32'h98b9; exp_one = 16'h0000; exp_two = 16'h0000;
        repeat (5) @(negedge I_CLK);
        I_ARST_N = 1'b1;
        @(negedge I_CLK);
        check(carry_n, 1'b1);
        check(oe, 1'b0);
        // Random counts, one round with counter two disabled
        for (int r = 0; r < 4; r++) begin
            n1 = (r == 0) ? 0 : int'(rnd() % 24);
            n2 = (r == 0) ? 1 : int'(rnd() % 24);
            en_two_n = (r == 2);
            for (int i = 0; i < ((n1 > n2) ? n1 : n2); i++)
                pulse(i < n1, i < n2);
            exp_one += n1[15:0];
            if (!en_two_n) exp_two += n2[15:0];
            snap_read(v);
            check(v, exp_snap(exp_one, exp_two));
            check(carry_n, 1'b1);
            check(oe, 1'b0);
            $display("round %0d done", r);
        end
        // Counting after a capture leaves the stored image alone
        prev = v;
        en_two_n = 1'b0;
        pulse(1'b1, 1'b1);
        read_bytes(v);
        check(v, prev);
        // Clear zeroes counters but not the stored image
        u_host.access(3'h5, b);
        read_bytes(v);
        check(v, prev);
        snap_read(v);
        check(v, 32'h0000_0000);
        u_host.access(3'h6, b);
        check(oe, 1'b0);
        $display("retain and clear done");
        // Chained pair: upper half holds until counter one wraps
        chain = 1'b1;
        n1 = int'(rnd() % 20) + 5;
        repeat (n1) pulse(1'b1, 1'b0);
        snap_read(v);
        check(v, exp_snap(n1[15:0], 16'h0000));
        check(carry_n, 1'b1);
        // Clock enable low: a pulse in that time leaves both counters alone
        I_CE = 1'b0;
        pulse(1'b1, 1'b0);
        I_CE = 1'b1;
        snap_read(v);
        check(v, exp_snap(n1[15:0], 16'h0000));
        $display("chained done");
        end_sim();
    end
endmodule
